//--- inc/dpso_params.svh
`ifndef DPSO_PARAMS_SVH
`define DPSO_PARAMS_SVH

// Register byte offsets.
`define DPSO_CTRL_OFS 8'h00
`define DPSO_TSHORT_TIME_OFS 8'h04
`define DPSO_OL_THRESH_OFS 8'h08
`define DPSO_OL_FILT_OFS 8'h0c
`define DPSO_STATUS_OFS 8'h10
`define DPSO_DI_FILT_BASE 8'h20
`define DPSO_DI_FILT_LAST 8'h3c

// Control register fields.
`define DPSO_CTRL_TSHORT_EN 0
`define DPSO_CTRL_SPD_INV 1
`define DPSO_CTRL_RST 2'h1

// Status register fields.
`define DPSO_ST_TSHORT 0
`define DPSO_ST_OLW 1
`define DPSO_ST_READY 2
`define DPSO_ST_FAULT 3
`define DPSO_ST_SPD 4
`define DPSO_ST_DI_LSB 8

// Reset values and limits.
`define DPSO_TSHORT_TIME_RST 7'h0a
`define DPSO_TSHORT_TIME_MIN 7'h01
`define DPSO_TSHORT_TIME_MAX 7'h64
`define DPSO_OL_THRESH_RST 10'h078
`define DPSO_OL_FILT_RST 10'h00a
`define DPSO_DI_FILT_RST 15'h0002
`define DPSO_TSHORT_CODE 8'h17

// Timing.
`define DPSO_CLK_PERIOD_NS 10
`define DPSO_STEP_NS 10000000
`define DPSO_DI_TICK_NS 1000

`endif

//--- inc/dpso_pkg.sv
package dpso_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dpso_wb_req_t;

  typedef struct packed {
    logic ctrl_power_ok;
    logic main_power_ok;
    logic accept_ok;
    logic fault_detected;
    logic torque_short;
    logic speed_limited;
    logic [9:0] current_pct;
  } dpso_drive_st_t;

  typedef enum logic {
    DPSO_TS_WATCH,
    DPSO_TS_TRIPPED
  } dpso_ts_state_t;

endpackage

//--- logic/dpso_di_filter.sv
`timescale 1ns/10ps
`include "dpso_params.svh"
module dpso_di_filter
  import dpso_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic raw_i,
  input wire logic [14:0] time_i,
  output logic filt_o
);

  logic filt_ff;
  logic nxt_filt;
  logic [14:0] cnt_ff;
  logic [14:0] nxt_cnt;

  // A new level is taken once it has held for the set number of ticks.
  always_comb begin
    nxt_filt = filt_ff;
    nxt_cnt = cnt_ff;
    if (raw_i == filt_ff) begin
      nxt_cnt = 15'h0000;
    end else if (time_i == 15'h0000 || cnt_ff >= time_i) begin
      nxt_filt = raw_i;
      nxt_cnt = 15'h0000;
    end else if (tick_i) begin
      nxt_cnt = cnt_ff + 15'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      filt_ff <= 1'b0;
      cnt_ff <= 15'h0000;
    end else if (ce_i) begin
      filt_ff <= nxt_filt;
      cnt_ff <= nxt_cnt;
    end
  end

  assign filt_o = filt_ff;

  di_pass_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ce_i && time_i == 15'h0000 |=> filt_o == $past(raw_i))
    else $error("Unfiltered input did not pass through.");

  di_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ce_i && time_i != 15'h0000 && cnt_ff < time_i |=> $stable(filt_o))
    else $error("Filtered input changed before its time.");

endmodule

//--- logic/dpso_top.sv
// Operation
// - Enabled torque shortfall raises alarm code.
// - Trip after shortfall persists set 10 ms steps.
// - Eight ordinary digital input terminals.
// - Per-input filter time, default two, immediate.
// - Fault output on when healthy, off on fault.
// - Ready only with power, acceptance, no alarm.
// - Overload warning after current persists at or above threshold.
// - Warning filter in 10 ms steps, immediate.
// - Speed-limit output while speed is limited, or while not limited if inverted.
`timescale 1ns/10ps
`include "dpso_params.svh"
module dpso_top
  import dpso_pkg::*;
#(
  parameter int STEP_CYCLES = `DPSO_STEP_NS / `DPSO_CLK_PERIOD_NS
)
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire dpso_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire dpso_drive_st_t drive_st_i,
  input wire logic [7:0] di_pin_i,
  output logic [7:0] di_filt_o,
  output logic [7:0] torque_shortfall_alarm_code_o,
  output logic fault_indicator_output_o,
  output logic drive_ready_output_o,
  output logic overload_warning_output_o,
  output logic speed_limit_output_o
);

  localparam int DI_TICK_CYCLES = `DPSO_DI_TICK_NS / `DPSO_CLK_PERIOD_NS;

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0] sel);
    lane_merge[7:0] = sel[0] ? dat[7:0] : old[7:0];
    lane_merge[15:8] = sel[1] ? dat[15:8] : old[15:8];
  endfunction

  function automatic logic [10:0] step_inc(input logic [10:0] v);
    step_inc = (v == 11'h7ff) ? v : v + 11'h001;
  endfunction

  function automatic logic di_hit(input logic [7:0] adr);
    di_hit = adr >= `DPSO_DI_FILT_BASE && adr <= `DPSO_DI_FILT_LAST &&
             adr[1:0] == 2'h0;
  endfunction

  logic [7:0] di_meta_ff;
  logic [7:0] di_sync_ff;
  logic [19:0] step_div_ff;
  logic [19:0] nxt_step_div;
  logic [6:0] di_div_ff;
  logic [6:0] nxt_di_div;
  logic step_tick;
  logic di_tick;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic [1:0] ctrl_ff;
  logic [1:0] nxt_ctrl;
  logic [6:0] ts_time_ff;
  logic [6:0] nxt_ts_time;
  logic [9:0] ol_thr_ff;
  logic [9:0] nxt_ol_thr;
  logic [9:0] ol_filt_ff;
  logic [9:0] nxt_ol_filt;
  logic [14:0] di_time_ff [8];
  logic [14:0] nxt_di_time [8];
  dpso_ts_state_t ts_state_ff;
  dpso_ts_state_t nxt_ts_state;
  logic [10:0] ts_cnt_ff;
  logic [10:0] nxt_ts_cnt;
  logic [10:0] ol_cnt_ff;
  logic [10:0] nxt_ol_cnt;
  logic olw_ff;
  logic nxt_olw;
  logic fault_ff;
  logic nxt_fault;
  logic ready_ff;
  logic nxt_ready;
  logic spd_ff;
  logic nxt_spd;
  logic [7:0] di_filt;
  logic wb_req;
  logic wb_wr;
  logic ol_over;
  logic [6:0] ts_limit;
  logic [15:0] st_word;
  logic [15:0] wr_word;

  assign step_tick = (step_div_ff == 20'(STEP_CYCLES - 1));
  assign di_tick = (di_div_ff == 7'(DI_TICK_CYCLES - 1));
  assign wb_req = wb_req_i.cyc && wb_req_i.stb;
  assign wb_wr = wb_req && wb_req_i.we && ack_ff;
  assign ol_over = drive_st_i.current_pct >= ol_thr_ff;
  assign ts_limit = (ts_time_ff < `DPSO_TSHORT_TIME_MIN) ?
                    `DPSO_TSHORT_TIME_MIN : ts_time_ff;

  // Status word as read by software.
  always_comb begin
    st_word = 16'h0000;
    st_word[`DPSO_ST_TSHORT] = (ts_state_ff == DPSO_TS_TRIPPED);
    st_word[`DPSO_ST_OLW] = olw_ff;
    st_word[`DPSO_ST_READY] = ready_ff;
    st_word[`DPSO_ST_FAULT] = fault_ff;
    st_word[`DPSO_ST_SPD] = spd_ff;
    st_word[`DPSO_ST_DI_LSB +: 8] = di_filt;
  end

  // Bus slave and configuration registers.
  always_comb begin
    logic [15:0] cur;
    cur = 16'h0000;
    nxt_ack = wb_req && !ack_ff;
    nxt_dat = dat_ff;
    nxt_ctrl = ctrl_ff;
    nxt_ts_time = ts_time_ff;
    nxt_ol_thr = ol_thr_ff;
    nxt_ol_filt = ol_filt_ff;
    nxt_di_time = di_time_ff;
    case (wb_req_i.adr)
      `DPSO_CTRL_OFS: cur = {14'h0000, ctrl_ff};
      `DPSO_TSHORT_TIME_OFS: cur = {9'h000, ts_time_ff};
      `DPSO_OL_THRESH_OFS: cur = {6'h00, ol_thr_ff};
      `DPSO_OL_FILT_OFS: cur = {6'h00, ol_filt_ff};
      `DPSO_STATUS_OFS: cur = st_word;
      default: begin
        if (di_hit(wb_req_i.adr)) begin
          cur = {1'b0, di_time_ff[wb_req_i.adr[4:2]]};
        end
      end
    endcase
    if (wb_req && !ack_ff) begin
      nxt_dat = wb_req_i.we ? 32'h0000_0000 : {16'h0000, cur};
    end
    wr_word = lane_merge(cur, wb_req_i.dat, wb_req_i.sel);
    if (wb_wr) begin
      case (wb_req_i.adr)
        `DPSO_CTRL_OFS: nxt_ctrl = wr_word[1:0];
        `DPSO_TSHORT_TIME_OFS: nxt_ts_time = wr_word[6:0];
        `DPSO_OL_THRESH_OFS: nxt_ol_thr = wr_word[9:0];
        `DPSO_OL_FILT_OFS: nxt_ol_filt = wr_word[9:0];
        default: begin
          if (di_hit(wb_req_i.adr)) begin
            nxt_di_time[wb_req_i.adr[4:2]] = wr_word[14:0];
          end
        end
      endcase
    end
  end

  // Monitoring: step timers, shortfall trip, overload, outputs.
  always_comb begin
    nxt_step_div = step_tick ? 20'h00000 : step_div_ff + 20'h00001;
    nxt_di_div = di_tick ? 7'h00 : di_div_ff + 7'h01;
    nxt_ts_state = ts_state_ff;
    nxt_ts_cnt = ts_cnt_ff;
    case (ts_state_ff)
      DPSO_TS_WATCH: begin
        if (!ctrl_ff[`DPSO_CTRL_TSHORT_EN] || !drive_st_i.torque_short) begin
          nxt_ts_cnt = 11'h000;
        end else if ({4'h0, ts_limit} <= ts_cnt_ff) begin
          nxt_ts_state = DPSO_TS_TRIPPED;
          nxt_ts_cnt = 11'h000;
        end else if (step_tick) begin
          nxt_ts_cnt = step_inc(ts_cnt_ff);
        end
      end
      DPSO_TS_TRIPPED: begin
        // Set wins: a clear is ignored while the shortfall persists.
        if (wb_wr && wb_req_i.adr == `DPSO_STATUS_OFS && wb_req_i.sel[0] &&
            wb_req_i.dat[`DPSO_ST_TSHORT] && !drive_st_i.torque_short) begin
          nxt_ts_state = DPSO_TS_WATCH;
        end
      end
      default: nxt_ts_state = DPSO_TS_WATCH;
    endcase
    nxt_ol_cnt = 11'h000;
    if (ol_over) begin
      nxt_ol_cnt = step_tick ? step_inc(ol_cnt_ff) : ol_cnt_ff;
    end
    nxt_olw = ol_over && ({1'b0, ol_filt_ff} <= ol_cnt_ff);
    nxt_fault = !(drive_st_i.fault_detected ||
                  nxt_ts_state == DPSO_TS_TRIPPED);
    nxt_ready = drive_st_i.accept_ok && drive_st_i.ctrl_power_ok &&
                drive_st_i.main_power_ok && nxt_fault;
    nxt_spd = drive_st_i.speed_limited ^
              ctrl_ff[`DPSO_CTRL_SPD_INV];
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      di_meta_ff <= 8'h00;
      di_sync_ff <= 8'h00;
      step_div_ff <= 20'h00000;
      di_div_ff <= 7'h00;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      ctrl_ff <= `DPSO_CTRL_RST;
      ts_time_ff <= `DPSO_TSHORT_TIME_RST;
      ol_thr_ff <= `DPSO_OL_THRESH_RST;
      ol_filt_ff <= `DPSO_OL_FILT_RST;
      di_time_ff <= '{default: `DPSO_DI_FILT_RST};
      ts_state_ff <= DPSO_TS_WATCH;
      ts_cnt_ff <= 11'h000;
      ol_cnt_ff <= 11'h000;
      olw_ff <= 1'b0;
      fault_ff <= 1'b0;
      ready_ff <= 1'b0;
      spd_ff <= 1'b0;
    end else if (ce_i) begin
      di_meta_ff <= di_pin_i;
      di_sync_ff <= di_meta_ff;
      step_div_ff <= nxt_step_div;
      di_div_ff <= nxt_di_div;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      ctrl_ff <= nxt_ctrl;
      ts_time_ff <= nxt_ts_time;
      ol_thr_ff <= nxt_ol_thr;
      ol_filt_ff <= nxt_ol_filt;
      di_time_ff <= nxt_di_time;
      ts_state_ff <= nxt_ts_state;
      ts_cnt_ff <= nxt_ts_cnt;
      ol_cnt_ff <= nxt_ol_cnt;
      olw_ff <= nxt_olw;
      fault_ff <= nxt_fault;
      ready_ff <= nxt_ready;
      spd_ff <= nxt_spd;
    end
  end

  // One filter per digital input terminal.
  for (genvar g = 0; g < 8; g++) begin : g_di
    dpso_di_filter u_filt (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .tick_i(di_tick),
      .raw_i(di_sync_ff[g]),
      .time_i(di_time_ff[g]),
      .filt_o(di_filt[g])
    );
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign di_filt_o = di_filt;
  assign torque_shortfall_alarm_code_o =
    (ts_state_ff == DPSO_TS_TRIPPED) ? `DPSO_TSHORT_CODE : 8'h00;
  assign fault_indicator_output_o = fault_ff;
  assign drive_ready_output_o = ready_ff;
  assign overload_warning_output_o = olw_ff;
  assign speed_limit_output_o = spd_ff;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  ack_single_a: assert property (ack_ff |=> !ack_ff)
    else $error("Bus acknowledge lasted more than one cycle.");
  trip_cause_a: assert property ($rose(ts_state_ff == DPSO_TS_TRIPPED)
    |-> $past(drive_st_i.torque_short && ctrl_ff[0]))
    else $error("Shortfall alarm without an enabled shortfall.");
  trip_early_a: assert property (
    ce_i && ts_state_ff == DPSO_TS_WATCH && ts_cnt_ff == 11'h000 &&
    ts_limit > 7'h01 |=> ts_state_ff == DPSO_TS_WATCH)
    else $error("Shortfall alarm tripped before its time.");
  fault_off_a: assert property (
    ce_i && drive_st_i.fault_detected |=> !fault_indicator_output_o)
    else $error("Fault output stayed on during a fault.");
  ready_off_a: assert property (
    ce_i && !drive_st_i.main_power_ok |=> !drive_ready_output_o)
    else $error("Ready output on without main power.");
  olw_off_a: assert property (
    ce_i && !ol_over |=> !overload_warning_output_o)
    else $error("Overload warning on below threshold.");
  olw_zero_a: assert property (
    ce_i && ol_over && ol_filt_ff == 10'h000 |=> overload_warning_output_o)
    else $error("Unfiltered overload warning was late.");
  spd_out_a: assert property (ce_i |=> speed_limit_output_o ==
    $past(drive_st_i.speed_limited ^ ctrl_ff[1]))
    else $error("Speed-limit output does not follow the limiter.");

  trip_c: cover property ($rose(ts_state_ff == DPSO_TS_TRIPPED));
  olw_c: cover property ($rose(overload_warning_output_o));
  ready_c: cover property ($rose(drive_ready_output_o));
  di_c: cover property ($changed(di_filt));

endmodule

//--- tb/dpso_host_model.sv
`timescale 1ns/10ps
module dpso_host_model (
  input wire logic clock_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] glitch_i,
  output logic [7:0] di_pin_o
);
  // Terminals seven and eight never carry short glitches.
  always_ff @(posedge clock_i) begin
    di_pin_o <= level_i ^ {2'b00, glitch_i[5:0]};
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  import dpso_pkg::*;
  localparam dpso_drive_st_t GOOD = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
                                      1'b0, 10'h000};
  logic clock_i;
  logic reset_n_i;
  dpso_wb_req_t req;
  dpso_drive_st_t st;
  logic [31:0] rd;
  logic [31:0] q;
  logic [7:0] lvl;
  logic [7:0] glt;
  logic [7:0] pins;
  logic [7:0] dfo;
  logic [7:0] code;
  logic flt;
  logic rdy;
  logic olw;
  logic spd;
  logic ack;
  int fails;
  int checks;
  int n;
  wire [4:0] ob = {spd, olw, rdy, flt, |code};

  dpso_top #(.STEP_CYCLES(10)) dut_u (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .wb_req_i(req), .wb_dat_o(rd), .wb_ack_o(ack), .drive_st_i(st),
    .di_pin_i(pins), .di_filt_o(dfo),
    .torque_shortfall_alarm_code_o(code),
    .fault_indicator_output_o(flt), .drive_ready_output_o(rdy),
    .overload_warning_output_o(olw), .speed_limit_output_o(spd));
  dpso_host_model host_u (.clock_i(clock_i), .level_i(lvl),
    .glitch_i(glt), .di_pin_o(pins));

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask

  // Waits on one observed output with a bounded count of cycles.
  task automatic wt(input int b, input logic v, input int lim);
    n = 0;
    while (ob[b] !== v) begin
      @(posedge clock_i);
      n++;
      if (n > lim) begin
        fails++;
        $display("Error wait %0d expected %b seen %b", b, v, ob[b]);
        complete_run();
      end
    end
  endtask

  // One classic Wishbone cycle, entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge clock_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rd;
    req <= '0;
    @(posedge clock_i);
    if (k >= 20) begin
      fails++;
      $display("Error ack expected 1 seen %b", ack);
      complete_run();
    end
  endtask

  task automatic rg(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic t_regs;
    rg("ctrl", 8'h00, 32'h1);
    rg("tshort", 8'h04, 32'ha);
    rg("ol_thr", 8'h08, 32'h78);
    rg("ol_filt", 8'h0c, 32'ha);
    for (int i = 0; i < 8; i++) begin
      rg("di_filt", 8'h20 + 8'(4 * i), 32'h2);
    end
    bus(1'b1, 8'h3c, 32'h7530);
    rg("di8_filt", 8'h3c, 32'h7530);
    bus(1'b1, 8'h3c, 32'h2);
    bus(1'b1, 8'h40, 32'hff);
    rg("unmapped", 8'h40, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_status;
    dpso_drive_st_t s;
    for (int i = 0; i < 5; i++) begin
      s = GOOD;
      if (i < 4) begin
        s[15 - i] = ~s[15 - i];
      end
      st <= s;
      cyc(3);
      chk("ready", 32'(i == 4), 32'(rdy));
      chk("fault", 32'(i != 3), 32'(flt));
    end
    rg("status", 8'h10, 32'hc);
    $display("test status done");
  endtask

  task automatic t_ol;
    bus(1'b1, 8'h0c, 32'h0);
    st.current_pct <= 10'h077;
    cyc(20);
    chk("warn_low", 32'h0, 32'(olw));
    st.current_pct <= 10'h078;
    wt(3, 1'b1, 3);
    st.current_pct <= 10'h000;
    wt(3, 1'b0, 3);
    bus(1'b1, 8'h08, 32'h320);
    bus(1'b1, 8'h0c, 32'h2);
    st.current_pct <= 10'h320;
    wt(3, 1'b1, 40);
    chk("warn_wait", 32'h1, 32'(n >= 10));
    st.current_pct <= 10'h000;
    wt(3, 1'b0, 3);
    $display("test overload done");
  endtask

  task automatic t_ts;
    bus(1'b1, 8'h04, 32'h2);
    st.torque_short <= 1'b1;
    wt(0, 1'b1, 40);
    chk("trip_wait", 32'h1, 32'(n >= 10));
    chk("code", 32'h17, 32'(code));
    chk("fault_off", 32'h0, 32'(flt));
    chk("ready_off", 32'h0, 32'(rdy));
    bus(1'b1, 8'h10, 32'h1);
    chk("code_hold", 32'h17, 32'(code));
    st.torque_short <= 1'b0;
    bus(1'b1, 8'h10, 32'h1);
    cyc(2);
    chk("code_clr", 32'h0, 32'(code));
    bus(1'b1, 8'h00, 32'h0);
    st.torque_short <= 1'b1;
    cyc(60);
    chk("code_off", 32'h0, 32'(code));
    st.torque_short <= 1'b0;
    bus(1'b1, 8'h00, 32'h1);
    $display("test shortfall done");
  endtask

  task automatic t_spd;
    st.speed_limited <= 1'b1;
    cyc(3);
    chk("spd", 32'h1, 32'(spd));
    bus(1'b1, 8'h00, 32'h3);
    cyc(2);
    chk("spd_inv", 32'h0, 32'(spd));
    st.speed_limited <= 1'b0;
    cyc(3);
    chk("spd_inv_idle", 32'h1, 32'(spd));
    bus(1'b1, 8'h00, 32'h1);
    $display("test speed done");
  endtask

  task automatic t_di;
    bus(1'b1, 8'h20, 32'h0);
    lvl <= 8'hff;
    cyc(8);
    chk("di_fast", 32'h1, 32'(dfo));
    cyc(400);
    chk("di_slow", 32'hff, 32'(dfo));
    glt <= 8'h3e;
    cyc(50);
    glt <= 8'h00;
    cyc(300);
    chk("di_glitch", 32'hff, 32'(dfo));
    bus(1'b1, 8'h24, 32'h0);
    lvl <= 8'h00;
    cyc(8);
    chk("di_imm", 32'hfc, 32'(dfo));
    cyc(400);
    chk("di_low", 32'h0, 32'(dfo));
    $display("test inputs done");
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    reset_n_i = 1'b0;
    req = '0;
    st = GOOD;
    lvl = 8'h00;
    glt = 8'h00;
    fails = 0;
    checks = 0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_status();
    t_ol();
    t_ts();
    t_spd();
    t_di();
    complete_run();
  end
endmodule
